// >>> src/line_fill_front_end.sv
// Purpose: Line style counter, vector address generator and fill gate front end.
// Assumes: AXI4-Lite slave, one clock, engine strobes on the same clock.
// Notes: Writes stall while the FIFO slot is full, back-pressuring the bus.
`timescale 1ns/1ps
module line_fill_front_end
  import line_fill_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // AXI4-Lite write
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  input wire logic [DATA_W-1:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  output logic [1:0] s_axi_bresp_o,
  // AXI4-Lite read
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  input wire logic [ADDR_W-1:0] s_axi_araddr_i,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic [DATA_W-1:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  // Styled pixel strobes
  input wire logic pixel_step_i,
  input wire logic pixel_last_i,
  output logic pixel_valid_o,
  output logic [DATA_W-1:0] pixel_colour_o,
  // Bus FIFO push
  output logic fifo_valid_o,
  output fifo_entry_t fifo_entry_o,
  input wire logic fifo_ready_i,
  // Fill probe
  input wire logic probe_valid_i,
  input wire logic [COORD_W-1:0] probe_x_i,
  input wire logic [COORD_W-1:0] probe_y_i,
  input wire logic [COORD_W-1:0] fill_left_x_i,
  input wire logic [COORD_W-1:0] fill_right_x_i,
  input wire logic [COORD_W-1:0] fill_top_y_i,
  input wire logic [COORD_W-1:0] fill_bottom_y_i,
  output logic fill_valid_o,
  output logic fill_draw_o
);
  // ------------------------------------------------------------
  // Bus write path
  // ------------------------------------------------------------
  logic aw_have_q, aw_have_d, w_have_q, w_have_d;
  logic [ADDR_W-1:0] aw_addr_q, aw_addr_d;
  logic [DATA_W-1:0] w_data_q, w_data_d;
  logic [3:0] w_strb_q, w_strb_d;
  logic awready_d, wready_d, bvalid_d;
  logic [1:0] bresp_d;
  logic do_write, slot_free;
  logic hit_win, hit_ap, hit_fwd, hit_opm, hit_shift, hit_local;

  assign slot_free = !fifo_valid_o || fifo_ready_i;
  assign hit_win = aw_addr_q[WINDOW_BIT];
  assign hit_ap = hit_win || aw_addr_q == DMA_APERTURE_ADDR;
  assign hit_fwd = !hit_win && aw_addr_q >= FWD_LO_ADDR && aw_addr_q <= FWD_HI_ADDR;
  assign hit_opm = aw_addr_q == OPERATING_MODE_REGISTER_ADDR;
  assign hit_shift = aw_addr_q == STYLE_SHIFT_ADDR;
  assign hit_local = aw_addr_q inside {SRC_WORD_0_ADDR, SRC_WORD_1_ADDR, SRC_WORD_2_ADDR,
    SRC_WORD_3_ADDR, STYLE_SHIFT_ADDR, FG_COLOUR_ADDR, BG_COLOUR_ADDR, LINE_CTRL_ADDR};
  assign do_write = aw_have_q && w_have_q && !s_axi_bvalid_o && slot_free;

  always_comb begin
    aw_have_d = aw_have_q;
    aw_addr_d = aw_addr_q;
    w_have_d = w_have_q;
    w_data_d = w_data_q;
    w_strb_d = w_strb_q;
    bvalid_d = s_axi_bvalid_o;
    bresp_d = s_axi_bresp_o;
    if (s_axi_bvalid_o && s_axi_bready_i) begin
      bvalid_d = 1'b0;
    end
    if (s_axi_awvalid_i && s_axi_awready_o) begin
      aw_have_d = 1'b1;
      aw_addr_d = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && s_axi_wready_o) begin
      w_have_d = 1'b1;
      w_data_d = s_axi_wdata_i;
      w_strb_d = s_axi_wstrb_i;
    end
    if (do_write) begin
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = (hit_ap || hit_fwd || hit_opm || hit_local) ? RESP_OKAY : RESP_SLVERR;
    end
    awready_d = !aw_have_d;
    wready_d = !w_have_d;
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= '0;
      w_strb_q <= '0;
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o <= 1'b0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= RESP_OKAY;
    end else begin
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      aw_addr_q <= aw_addr_d;
      w_data_q <= w_data_d;
      w_strb_q <= w_strb_d;
      s_axi_awready_o <= awready_d;
      s_axi_wready_o <= wready_d;
      s_axi_bvalid_o <= bvalid_d;
      s_axi_bresp_o <= bresp_d;
    end
  end

  // ------------------------------------------------------------
  // Register file
  // ------------------------------------------------------------
  logic [3:0][DATA_W-1:0] src_q, src_d;
  logic [DATA_W-1:0] fg_q, fg_d, bg_q, bg_d, opm_q, opm_d;
  logic [STYLE_W-1:0] len_q, len_d;
  logic closed_q, closed_d;

  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] o, input logic [DATA_W-1:0] n,
                                               input logic [3:0] s);
    logic [DATA_W-1:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[b*8 +: 8] = n[b*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  always_comb begin
    src_d = src_q;
    fg_d = fg_q;
    bg_d = bg_q;
    opm_d = opm_q;
    len_d = len_q;
    closed_d = closed_q;
    if (do_write) begin
      unique case (aw_addr_q)
        SRC_WORD_0_ADDR: src_d[0] = merge(src_q[0], w_data_q, w_strb_q);
        SRC_WORD_1_ADDR: src_d[1] = merge(src_q[1], w_data_q, w_strb_q);
        SRC_WORD_2_ADDR: src_d[2] = merge(src_q[2], w_data_q, w_strb_q);
        SRC_WORD_3_ADDR: src_d[3] = merge(src_q[3], w_data_q, w_strb_q);
        FG_COLOUR_ADDR: fg_d = merge(fg_q, w_data_q, w_strb_q);
        BG_COLOUR_ADDR: bg_d = merge(bg_q, w_data_q, w_strb_q);
        OPERATING_MODE_REGISTER_ADDR: opm_d = merge(opm_q, w_data_q, w_strb_q);
        STYLE_SHIFT_ADDR: len_d = w_strb_q[0] ? w_data_q[STYLE_W-1:0] : len_q;
        LINE_CTRL_ADDR: closed_d = w_strb_q[0] ? w_data_q[CTRL_CLOSED_BIT] : closed_q;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      src_q <= '0;
      fg_q <= WORD_ZERO;
      bg_q <= WORD_ZERO;
      opm_q <= OPERATING_MODE_REGISTER_RESET;
      len_q <= '0;
      closed_q <= 1'b0;
    end else begin
      src_q <= src_d;
      fg_q <= fg_d;
      bg_q <= bg_d;
      opm_q <= opm_d;
      len_q <= len_d;
      closed_q <= closed_d;
    end
  end

  // ------------------------------------------------------------
  // Line style counter and colour
  // ------------------------------------------------------------
  localparam int BIT_SEL_W = $clog2(DATA_W);
  logic [STYLE_W-1:0] cnt_q, cnt_d;
  logic pix_valid_d, style_bit, shift_wr;
  logic [DATA_W-1:0] pix_colour_d;

  assign shift_wr = do_write && hit_shift && w_strb_q[COUNT_LSB/8];
  // bit chosen by counter; a shift write can load a count beyond length
  assign style_bit = src_q[cnt_q[STYLE_W-1:BIT_SEL_W]][cnt_q[BIT_SEL_W-1:0]];

  always_comb begin
    cnt_d = cnt_q;
    // open line omits its last pixel
    pix_valid_d = pixel_step_i && !(pixel_last_i && !closed_q);
    // foreground on one, background on zero
    pix_colour_d = style_bit ? fg_q : bg_q;
    if (shift_wr) begin
      cnt_d = w_data_q[COUNT_LSB +: STYLE_W];
    // last pixel holds, next vector resumes
    end else if (pixel_step_i && !pixel_last_i) begin
      cnt_d = (cnt_q == '0) ? len_q : cnt_q - 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      cnt_q <= '0;
      pixel_valid_o <= 1'b0;
      pixel_colour_o <= WORD_ZERO;
    end else begin
      cnt_q <= cnt_d;
      pixel_valid_o <= pix_valid_d;
      pixel_colour_o <= pix_valid_d ? pix_colour_d : pixel_colour_o;
    end
  end

  // ------------------------------------------------------------
  // Vector address generator and FIFO push
  // ------------------------------------------------------------
  agen_state_t ag_q, ag_d;
  logic [DATA_W-1:0] tags_q, tags_d;
  logic [TAG_CNT_W-1:0] tcnt_q, tcnt_d;
  logic fifo_valid_d, vec_push;
  fifo_entry_t entry_d;

  assign vec_push = do_write && hit_ap && ag_q == AG_DATA;

  always_comb begin
    ag_d = ag_q;
    tags_d = tags_q;
    tcnt_d = tcnt_q;
    entry_d = fifo_entry_o;
    fifo_valid_d = fifo_valid_o && !fifo_ready_i;
    // byte zero of operating mode aborts
    if (do_write && hit_opm && w_strb_q[0]) begin
      ag_d = AG_TAGS;
      tcnt_d = '0;
    end else if (do_write && hit_ap && ag_q == AG_TAGS) begin
      tags_d = w_data_q;
      tcnt_d = '0;
      ag_d = AG_DATA;
    end else if (vec_push) begin
      fifo_valid_d = 1'b1;
      entry_d.go = tags_q[tcnt_q];
      entry_d.index = tags_q[tcnt_q] ? END_POS_IDX : START_POS_IDX;
      entry_d.x = w_data_q[COORD_W-1:0];
      entry_d.y = w_data_q[DATA_W-1:COORD_W];
      tcnt_d = tcnt_q + 1'b1;
      if (tcnt_q == LAST_TAG) begin
        ag_d = AG_TAGS;
      end
    end else if (do_write && hit_fwd) begin
      // start only from the 1D00h range
      fifo_valid_d = 1'b1;
      entry_d.go = aw_addr_q >= GO_LO_ADDR;
      entry_d.index = reg_index(aw_addr_q);
      entry_d.x = w_data_q[COORD_W-1:0];
      entry_d.y = w_data_q[DATA_W-1:COORD_W];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      ag_q <= AG_TAGS;
      tags_q <= WORD_ZERO;
      tcnt_q <= '0;
      fifo_valid_o <= 1'b0;
      fifo_entry_o <= '0;
    end else begin
      ag_q <= ag_d;
      tags_q <= tags_d;
      tcnt_q <= tcnt_d;
      fifo_valid_o <= fifo_valid_d;
      fifo_entry_o <= entry_d;
    end
  end

  // ------------------------------------------------------------
  // Bus read path
  // ------------------------------------------------------------
  logic rvalid_d, arready_d;
  logic [DATA_W-1:0] rdata_d;
  logic [1:0] rresp_d;

  always_comb begin
    rvalid_d = s_axi_rvalid_o && !s_axi_rready_i;
    rdata_d = s_axi_rdata_o;
    rresp_d = s_axi_rresp_o;
    if (s_axi_arvalid_i && s_axi_arready_o) begin
      rvalid_d = 1'b1;
      rresp_d = RESP_OKAY;
      rdata_d = WORD_ZERO;
      unique case (s_axi_araddr_i)
        SRC_WORD_0_ADDR: rdata_d = src_q[0];
        SRC_WORD_1_ADDR: rdata_d = src_q[1];
        SRC_WORD_2_ADDR: rdata_d = src_q[2];
        SRC_WORD_3_ADDR: rdata_d = src_q[3];
        FG_COLOUR_ADDR: rdata_d = fg_q;
        BG_COLOUR_ADDR: rdata_d = bg_q;
        OPERATING_MODE_REGISTER_ADDR: rdata_d = opm_q;
        STYLE_SHIFT_ADDR: begin
          rdata_d[STYLE_W-1:0] = len_q;
          rdata_d[COUNT_LSB +: STYLE_W] = cnt_q;
        end
        LINE_CTRL_ADDR: rdata_d[CTRL_CLOSED_BIT] = closed_q;
        STATUS_ADDR: begin
          rdata_d[STAT_STATE_BIT] = ag_q;
          rdata_d[STAT_CNT_LSB +: TAG_CNT_W] = tcnt_q;
          rdata_d[STAT_FIFO_BIT] = fifo_valid_o;
        end
        default: rresp_d = RESP_SLVERR;
      endcase
    end
    arready_d = !rvalid_d;
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_arready_o <= 1'b0;
      s_axi_rdata_o <= WORD_ZERO;
      s_axi_rresp_o <= RESP_OKAY;
    end else begin
      s_axi_rvalid_o <= rvalid_d;
      s_axi_arready_o <= arready_d;
      s_axi_rdata_o <= rdata_d;
      s_axi_rresp_o <= rresp_d;
    end
  end

  fill_edge_gate #(.W(COORD_W)) u_fill_gate (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .probe_valid_i(probe_valid_i),
    .probe_x_i(probe_x_i),
    .probe_y_i(probe_y_i),
    .left_i(fill_left_x_i),
    .right_i(fill_right_x_i),
    .top_i(fill_top_y_i),
    .bottom_i(fill_bottom_y_i),
    .valid_o(fill_valid_o),
    .draw_o(fill_draw_o)
  );

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  chk_count_wrap: assert property (
    pixel_step_i && !pixel_last_i && !shift_wr && cnt_q == '0 |=> cnt_q == $past(len_q))
    else $error("style counter did not wrap to length");
  chk_count_down: assert property (
    pixel_step_i && !pixel_last_i && !shift_wr && cnt_q != '0 |=> cnt_q == $past(cnt_q) - 1'b1)
    else $error("style counter did not count down");
  chk_last_hold: assert property (
    pixel_step_i && pixel_last_i && !shift_wr |=> $stable(cnt_q))
    else $error("style counter moved on last pixel");
  chk_colour_pick: assert property (
    pixel_step_i && !pixel_last_i |=> pixel_valid_o
      && pixel_colour_o == ($past(style_bit) ? $past(fg_q) : $past(bg_q)))
    else $error("wrong styled colour");
  chk_open_skip: assert property (
    pixel_step_i && pixel_last_i && !closed_q |=> !pixel_valid_o)
    else $error("open line drew its last pixel");
  chk_operating_mode_register_abort: assert property (
    do_write && hit_opm && w_strb_q[0] |=> ag_q == AG_TAGS && tcnt_q == '0)
    else $error("address generator not reset");
  chk_tag_route: assert property (
    vec_push |=> fifo_valid_o && fifo_entry_o.go == $past(tags_q[tcnt_q])
      && fifo_entry_o.index == (fifo_entry_o.go ? END_POS_IDX : START_POS_IDX))
    else $error("vertex routed to wrong index");
  chk_tags_reload: assert property (
    vec_push && tcnt_q == LAST_TAG |=> ag_q == AG_TAGS)
    else $error("no tag reload after last tag");
  chk_xy_split: assert property (
    vec_push |=> fifo_entry_o.x == $past(w_data_q[COORD_W-1:0])
      && fifo_entry_o.y == $past(w_data_q[DATA_W-1:COORD_W]))
    else $error("vertex coordinates split wrongly");
  chk_go_range: assert property (
    fifo_valid_o && fifo_entry_o.go |-> fifo_entry_o.index >= GO_IDX_LO && fifo_entry_o.index <= GO_IDX_HI)
    else $error("engine start outside range");
  chk_fifo_hold: assert property (
    fifo_valid_o && !fifo_ready_i |=> fifo_valid_o && $stable(fifo_entry_o))
    else $error("fifo entry dropped");

  cov_style_wrap: cover property (pixel_step_i && !pixel_last_i && cnt_q == '0 && len_q != '0);
  cov_tag_reload: cover property (vec_push && tcnt_q == LAST_TAG);
  cov_vec_start: cover property (vec_push && tags_q[tcnt_q]);
endmodule : line_fill_front_end

// >>> src/line_fill_pkg.sv
// Purpose: Shared constants and types for the line and fill setup front end.
// Assumes: AXI4-Lite register bus, 32-bit data, 24-bit byte addresses.
// Notes: Drawing register indices are {addr[13], addr[8:2]}.
//
// Notes on behaviour
// - Style pattern lives in four 32-bit source words; high words used per length.
// - Style counter counts down per styled pixel, wraps from zero to length.
// - After a line the counter points at the pattern bit of its final pixel.
// - A line, closed or open, does not advance the counter on its final pixel.
// - Style bit one writes foreground colour, zero writes background colour.
// - A write touching operating mode byte zero resets the address generator.
// - Vector transfer begins on a write to the aperture or the 8 MByte window.
// - First packet dword loads 32 tags; next 32 dwords are vertices.
// - Tag zero routes vertex to start position index, no engine start.
// - Tag one routes vertex to end position index with engine start flag.
// - Each data dword pushes an 8-bit index with its data to the FIFO.
// - After the 32nd tag the next dword is a fresh tag word.
// - Engine starts only when the last setup access lies in 1D00h-1DFFh.
// - Fills draw top and left edges, exclude bottom and right edges.
// - Closed lines draw the final pixel; open lines omit it.
package line_fill_pkg;
  localparam int ADDR_W = 24;
  localparam int DATA_W = 32;
  localparam int STYLE_W = 7;
  localparam int TAG_CNT_W = 5;
  localparam int WINDOW_BIT = 23;
  localparam int IDX_HI_BIT = 13;
  localparam int COORD_W = 16;
  // ------------------------------------------------------------
  // Register byte addresses
  // ------------------------------------------------------------
  localparam logic [ADDR_W-1:0] SRC_WORD_0_ADDR = 24'h001C00;
  localparam logic [ADDR_W-1:0] SRC_WORD_1_ADDR = 24'h001C04;
  localparam logic [ADDR_W-1:0] SRC_WORD_2_ADDR = 24'h001C08;
  localparam logic [ADDR_W-1:0] SRC_WORD_3_ADDR = 24'h001C0C;
  localparam logic [ADDR_W-1:0] STYLE_SHIFT_ADDR = 24'h001C10;
  localparam logic [ADDR_W-1:0] FG_COLOUR_ADDR = 24'h001C14;
  localparam logic [ADDR_W-1:0] BG_COLOUR_ADDR = 24'h001C18;
  localparam logic [ADDR_W-1:0] LINE_CTRL_ADDR = 24'h001C1C;
  localparam logic [ADDR_W-1:0] DMA_APERTURE_ADDR = 24'h001C20;
  localparam logic [ADDR_W-1:0] STATUS_ADDR = 24'h001C24;
  localparam logic [ADDR_W-1:0] OPERATING_MODE_REGISTER_ADDR = 24'h001E54;
  localparam logic [ADDR_W-1:0] FWD_LO_ADDR = 24'h001C40;
  localparam logic [ADDR_W-1:0] FWD_HI_ADDR = 24'h001DFF;
  localparam logic [ADDR_W-1:0] GO_LO_ADDR = 24'h001D00;
  localparam logic [ADDR_W-1:0] START_POS_ADDR = 24'h001C40;
  localparam logic [ADDR_W-1:0] END_POS_ADDR = 24'h001D44;
  // ------------------------------------------------------------
  // Fields and reset values
  // ------------------------------------------------------------
  localparam int COUNT_LSB = 16;
  localparam int CTRL_CLOSED_BIT = 0;
  localparam int STAT_STATE_BIT = 0;
  localparam int STAT_CNT_LSB = 8;
  localparam int STAT_FIFO_BIT = 16;
  localparam logic [DATA_W-1:0] OPERATING_MODE_REGISTER_RESET = 32'h00000000;
  localparam logic [DATA_W-1:0] WORD_ZERO = 32'h00000000;
  localparam logic [TAG_CNT_W-1:0] LAST_TAG = 5'h1F;
  localparam logic [7:0] GO_IDX_LO = 8'h40;
  localparam logic [7:0] GO_IDX_HI = 8'h7F;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [0:0] {AG_TAGS = 1'b0, AG_DATA = 1'b1} agen_state_t;

  typedef struct packed {
    logic [7:0] index;
    logic go;
    logic [COORD_W-1:0] y;
    logic [COORD_W-1:0] x;
  } fifo_entry_t;

  function automatic logic [7:0] reg_index(input logic [ADDR_W-1:0] a);
    return {a[IDX_HI_BIT], a[8:2]};
  endfunction : reg_index

  localparam logic [7:0] START_POS_IDX = reg_index(START_POS_ADDR);
  localparam logic [7:0] END_POS_IDX = reg_index(END_POS_ADDR);
endpackage : line_fill_pkg

// >>> src/fill_edge_gate.sv
// Purpose: Decides whether a fill probe pixel belongs to the primitive.
// Assumes: Probe inputs come from logic on the same clock.
// Notes: Result appears one cycle after the probe.
`timescale 1ns/1ps
module fill_edge_gate
  import line_fill_pkg::*;
#(
  parameter int W = COORD_W
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Probe
  input wire logic probe_valid_i,
  input wire logic [W-1:0] probe_x_i,
  input wire logic [W-1:0] probe_y_i,
  input wire logic [W-1:0] left_i,
  input wire logic [W-1:0] right_i,
  input wire logic [W-1:0] top_i,
  input wire logic [W-1:0] bottom_i,
  // Result
  output logic valid_o,
  output logic draw_o
);
  logic valid_d;
  logic draw_d;

  always_comb begin
    valid_d = probe_valid_i;
    draw_d = probe_valid_i && (probe_x_i >= left_i) && (probe_x_i < right_i)
             && (probe_y_i >= top_i) && (probe_y_i < bottom_i);
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      valid_o <= 1'b0;
      draw_o <= 1'b0;
    end else begin
      valid_o <= valid_d;
      draw_o <= draw_d;
    end
  end

  chk_right_excluded: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    probe_valid_i && probe_x_i == right_i |=> !draw_o) else $error("right edge pixel drawn");
  cov_fill_draw: cover property (@(posedge clk_i) disable iff (!reset_n_i) valid_o && draw_o);
endmodule : fill_edge_gate

// >>> testbench/fifo_sink.sv
// Purpose: Far-side model of the bus FIFO that takes pushed entries.
// Assumes: Same clock as the front end.
// Notes: With slow_i high it accepts only every other cycle.
`timescale 1ns/1ps
module fifo_sink
  import line_fill_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Push side
  input wire logic valid_i,
  input wire fifo_entry_t entry_i,
  input wire logic slow_i,
  output logic ready_o
);
  logic tick_q;
  fifo_entry_t got[$];
  assign ready_o = !slow_i || tick_q;
  always_ff @(posedge clk_i) begin
    tick_q <= reset_n_i && !tick_q;
    if (reset_n_i && valid_i && ready_o) begin
      got.push_back(entry_i);
    end
  end
endmodule : fifo_sink

// >>> testbench/testbench.sv
// Purpose: Self-checking bench for the line and fill front end.
// Assumes: Bench acts as AXI4-Lite host; fifo_sink takes pushes.
// Notes: Fill edges are driven by the fill scenario itself.
`timescale 1ns/1ps
module testbench
  import line_fill_pkg::*;
;
  logic clk, rst_n, awv, awr, wv_, wr_, bv, br, arv, arr, rv, rr, st, ls, pvl, pv, fv, fr, pb, dr, slow;
  logic [23:0] awa, ara;
  logic [31:0] wd, rd_, col;
  logic [3:0] ws;
  logic [1:0] bre, rre;
  logic [15:0] px, py, edg_l, edg_r, edg_t, edg_b;
  fifo_entry_t ent;
  int err_total, samples_checked;
  line_fill_front_end dut (.clk_i(clk), .reset_n_i(rst_n), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
    .s_axi_awaddr_i(awa), .s_axi_wvalid_i(wv_), .s_axi_wready_o(wr_), .s_axi_wdata_i(wd), .s_axi_wstrb_i(ws),
    .s_axi_bvalid_o(bv), .s_axi_bready_i(br), .s_axi_bresp_o(bre), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
    .s_axi_araddr_i(ara), .s_axi_rvalid_o(rv), .s_axi_rready_i(rr), .s_axi_rdata_o(rd_), .s_axi_rresp_o(rre),
    .pixel_step_i(st), .pixel_last_i(ls), .pixel_valid_o(pv), .pixel_colour_o(col), .fifo_valid_o(fv),
    .fifo_entry_o(ent), .fifo_ready_i(fr), .probe_valid_i(pb), .probe_x_i(px), .probe_y_i(py),
    .fill_left_x_i(edg_l), .fill_right_x_i(edg_r), .fill_top_y_i(edg_t), .fill_bottom_y_i(edg_b),
    .fill_valid_o(pvl), .fill_draw_o(dr));
  fifo_sink sink (.clk_i(clk), .reset_n_i(rst_n), .valid_i(fv), .entry_i(ent), .slow_i(slow), .ready_o(fr));
  // ------------------------------------------------------------
  // Host bus and check tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [23:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    awa <= a;
    wd <= d;
    ws <= s;
    awv <= 1'b1;
    wv_ <= 1'b1;
    br <= 1'b1;
    for (int n = 0; n < 100; n++) begin
      @(posedge clk);
      if (awv && awr) awv <= 1'b0;
      if (wv_ && wr_) wv_ <= 1'b0;
      if (bv) break;
    end
    chk({bv, bre}, {1'b1, er});
  endtask : wr
  task automatic rd(input logic [23:0] a, input logic [31:0] ed, input logic [1:0] er);
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    for (int n = 0; n < 100; n++) begin
      @(posedge clk);
      if (arv && arr) arv <= 1'b0;
      if (rv) break;
    end
    chk({rv, rre, rd_}, {1'b1, er, ed});
  endtask : rd
  // Write, let the sink drain, then check what was pushed
  task automatic wp(input logic [23:0] a, input logic [31:0] d, input logic push, input logic [7:0] idx);
    wr(a, d, 4'hF, 2'h0);
    for (int n = 0; n < 20 && fv; n++) @(posedge clk);
    chk(sink.got.size(), push);
    // Start flag is expected from index bit 6, as for indices 40h..7Fh
    if (push) chk(sink.got.pop_front(), {idx, idx[6], d});
  endtask : wp
  task automatic pix(input logic l, input logic ev, input logic [31:0] ec);
    st <= 1'b1;
    ls <= l;
    @(posedge clk);
    st <= 1'b0;
    @(negedge clk);
    chk(pv, ev);
    if (ev) chk(col, ec);
    @(posedge clk);
  endtask : pix
  task automatic probe(input logic [15:0] x, input logic [15:0] y, input logic ed);
    px <= x;
    py <= y;
    pb <= 1'b1;
    @(posedge clk);
    pb <= 1'b0;
    @(negedge clk);
    chk({pvl, dr}, {1'b1, ed});
    @(posedge clk);
  endtask : probe
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_dma();
    slow <= 1'b1;
    wr(OPERATING_MODE_REGISTER_ADDR, 32'h0000_0008, 4'h3, 2'h0);
    wp(DMA_APERTURE_ADDR, 32'h8000_0001, 1'b0, 8'h00);
    for (int i = 0; i < 32; i++) begin
      wp(24'h80_0000 + 24'(4 * i), {16'(i), 16'(i + 7)}, 1'b1, (i == 0 || i == 31) ? 8'h51 : 8'h10);
    end
    wp(24'h80_0000, 32'h0000_0000, 1'b0, 8'h00);
    wp(DMA_APERTURE_ADDR, 32'h0003_0004, 1'b1, 8'h10);
    wr(OPERATING_MODE_REGISTER_ADDR, 32'h0000_0008, 4'h1, 2'h0);
    wp(DMA_APERTURE_ADDR, 32'hFFFF_FFFF, 1'b0, 8'h00);
    wp(DMA_APERTURE_ADDR, 32'h0005_0006, 1'b1, 8'h51);
    // Generator now in data state with one tag used and the FIFO slot idle
    rd(STATUS_ADDR, 32'h0000_0101, 2'h0);
    rd(OPERATING_MODE_REGISTER_ADDR, 32'h0000_0008, 2'h0);
    $display("test dma done");
  endtask : t_dma
  task automatic t_direct();
    wp(24'h00_1D00, 32'h0012_0034, 1'b1, 8'h40);
    wp(24'h00_1C44, 32'h0056_0078, 1'b1, 8'h11);
    wr(24'h00_0100, 32'h0000_0001, 4'hF, 2'h2);
    rd(24'h00_0100, 32'h0000_0000, 2'h2);
    $display("test direct done");
  endtask : t_direct
  task automatic t_style();
    wr(SRC_WORD_0_ADDR, 32'h0000_0002, 4'hF, 2'h0);
    wr(SRC_WORD_1_ADDR, 32'h0000_0008, 4'hF, 2'h0);
    // lines without depth, colours for 32-bit pixels
    wr(FG_COLOUR_ADDR, 32'hAAAA_5555, 4'hF, 2'h0);
    wr(BG_COLOUR_ADDR, 32'h0000_FFFF, 4'hF, 2'h0);
    wr(LINE_CTRL_ADDR, 32'h0000_0001, 4'hF, 2'h0);
    wr(STYLE_SHIFT_ADDR, 32'h0001_0023, 4'hF, 2'h0);
    pix(1'b0, 1'b1, 32'hAAAA_5555);
    pix(1'b0, 1'b1, 32'h0000_FFFF);
    pix(1'b0, 1'b1, 32'hAAAA_5555);
    pix(1'b1, 1'b1, 32'h0000_FFFF);
    rd(STYLE_SHIFT_ADDR, 32'h0022_0023, 2'h0);
    wr(LINE_CTRL_ADDR, 32'h0000_0000, 4'hF, 2'h0);
    pix(1'b1, 1'b0, 32'h0000_0000);
    pix(1'b0, 1'b1, 32'h0000_FFFF);
    $display("test style done");
  endtask : t_style
  task automatic t_fill();
    edg_l <= 16'h000A;
    edg_r <= 16'h0014;
    edg_t <= 16'h0005;
    edg_b <= 16'h0008;
    probe(16'h000A, 16'h0005, 1'b1);
    probe(16'h0013, 16'h0007, 1'b1);
    probe(16'h0014, 16'h0006, 1'b0);
    probe(16'h000C, 16'h0008, 1'b0);
    probe(16'h0009, 16'h0006, 1'b0);
    // Zero-width span, as at a triangle tip
    edg_r <= 16'h000A;
    probe(16'h000A, 16'h0006, 1'b0);
    $display("test fill done");
  endtask : t_fill
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : wrap_up
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    {rst_n, awv, wv_, br, arv, rr, st, ls, pb, slow, awa, ara, wd, ws, px, py, edg_l, edg_r, edg_t, edg_b} = '0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    t_direct();
    t_dma();
    t_style();
    t_fill();
    wrap_up();
  end
  // Run needs well under 2000 cycles
  initial begin
    #40000;
    err_total++;
    wrap_up();
  end
endmodule : testbench
